//--- verilog/uvcd_decoder.sv
// USB vendor request decoder and IN pipe router for the pulse processor
//
// Overview of operation
// - Pipes 0,1,2 are config, status, spectrum.
// - Pipe 3 shares readback, scope, text.
// - Unready IN pipe returns zero-length first.
// - Commands are vendor requests on endpoint 0.
// - 0x80 clear, 0x82 start, 0x83 stop, 0x84 arm.
// - 0x85 fine search, 0x86 coarse then fine.
// - 0x87 sets fast threshold, quiet background.
// - 0x88-0x8F clear/set general lines 0-3.
// - 0x90 loads diode DAC, saves, board EEPROM if board present.
// - 0x91 low pole-zero, high temperature calibration.
// - 0x92 delivers boot flags, kept nonvolatile.
// - 0x93-0x95 legacy bias, temperature, offset DACs.
// - 0x96 converter calibration, 0x97 spectrum offset.
// - 0x98 selects scope (0) or text (1).
// - 0x7F writes one 32 byte chunk of the 512 byte block.
// - Firmware byte 0x50 marks newer generation.
// - Status bit seven reports emulation mode.
// - Full mode takes settings from configuration.
// - Device mode change needs power cycle.
// - Boot flag picks 115.2 or 57.6 kbaud.
// - After select: empty read, payload, revert.
// - Scope select ignored when scope unready.
`default_nettype none
module uvcd_decoder (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic setup_valid_i,
   input wire uvcd_pkg::uvcd_setup_type setup_i,
   output logic setup_ack_o,
   output logic setup_stall_o,
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   input wire logic in_req_i,
   input wire logic [2:0] in_pipe_i,
   output logic in_ans_valid_o,
   output uvcd_pkg::uvcd_in_ans_type in_ans_o,
   input wire logic status_ready_i,
   input wire logic spectrum_ready_i,
   input wire logic scope_ready_i,
   input wire logic [11:0] cfg_bias_i,
   input wire logic [11:0] cfg_cooler_i,
   input wire logic [11:0] cfg_offset_i,
   input wire logic cfg_adc_invert_i,
   input wire logic [15:0] boot_nv_i,
   input wire logic board_present_i,
   input wire logic [8:0] text_rd_addr_i,
   output logic [7:0] text_rd_data_o,
   output logic text_nv_copy_o,
   output logic clear_spectrum_o,
   output logic acq_enable_o,
   output logic scope_arm_o,
   output logic offset_fine_o,
   output logic offset_full_o,
   output logic fast_thr_o,
   output logic [3:0] general_line_o,
   output logic [11:0] diode_cal_o,
   output logic board_eeprom_wr_o,
   output logic settings_nv_wr_o,
   output logic [7:0] pole_zero_o,
   output logic [7:0] temp_cal_o,
   output logic [15:0] boot_flags_o,
   output logic [7:0] hk_gain_o,
   output logic [7:0] hk_offset_o,
   output logic [15:0] spec_offset_o,
   output logic [11:0] bias_o,
   output logic [11:0] cooler_o,
   output logic [11:0] in_offset_o,
   output logic adc_invert_o,
   output logic emulation_full_o,
   output logic baud_fast_o,
   output logic [7:0] fw_version_o
);
   import uvcd_pkg::*;

   typedef enum logic [1:0] {SH_CONFIG, SH_ARMED, SH_PAYLOAD} uvcd_shared_type;

   // ************************************************************
   // Request decode
   // ************************************************************
   logic vendor;
   logic known;
   logic [7:0] rq;
   logic board_sync;
   uvcd_shared_type shared_q;
   uvcd_src_type sel_q;
   logic [11:0] legacy_bias_q;
   logic [11:0] legacy_temp_q;
   logic [11:0] legacy_ofs_q;
   logic boot_adc_inv_q;
   logic boot_done_q;
   logic text_act_q;
   logic [3:0] text_idx_q;
   logic [4:0] text_off_q;
   logic [15:0] text_left_q;
   logic text_wr;

   assign rq = setup_i.request;
   assign vendor = ce_i && setup_valid_i && (setup_i.req_type[6:5] == TYPE_VENDOR);
   // 0x81 is a retired code and stays unknown
   assign known = (rq >= REQ_WRITE_TEXT) && (rq <= REQ_RSV_LAST) && (rq != 8'h81);

   uvcd_sync2 u_board_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .async_i(board_present_i),
      .sync_o(board_sync)
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         setup_ack_o <= 1'b0;
         setup_stall_o <= 1'b0;
      end else if (ce_i) begin
         setup_ack_o <= vendor && known;
         setup_stall_o <= vendor && !known;
      end
   end

   // ************************************************************
   // Acquisition commands
   // ************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clear_spectrum_o <= 1'b0;
         scope_arm_o <= 1'b0;
         offset_fine_o <= 1'b0;
         offset_full_o <= 1'b0;
         fast_thr_o <= 1'b0;
      end else if (ce_i) begin
         clear_spectrum_o <= vendor && (rq == REQ_CLEAR);
         scope_arm_o <= vendor && (rq == REQ_ARM);
         offset_fine_o <= vendor && (rq == REQ_OFS_FINE);
         offset_full_o <= vendor && (rq == REQ_OFS_FULL);
         // Only meaningful with no source and very low background
         fast_thr_o <= vendor && (rq == REQ_FAST_THR);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acq_enable_o <= 1'b0;
      end else if (vendor && (rq == REQ_START)) begin
         acq_enable_o <= 1'b1;
      end else if (vendor && (rq == REQ_STOP)) begin
         acq_enable_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         general_line_o <= 4'h0;
      end else if (vendor && (rq >= REQ_LINE_FIRST) && (rq <= REQ_LINE_LAST)) begin
         general_line_o[rq[2:1]] <= rq[0];
      end
   end

   // ************************************************************
   // Saved settings
   // ************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         diode_cal_o <= DAC_RESET;
         pole_zero_o <= 8'h00;
         temp_cal_o <= 8'h00;
         boot_flags_o <= BOOT_RESET;
         hk_gain_o <= 8'h00;
         hk_offset_o <= 8'h00;
         spec_offset_o <= 16'h0000;
         legacy_bias_q <= DAC_RESET;
         legacy_temp_q <= DAC_RESET;
         legacy_ofs_q <= DAC_RESET;
      end else if (vendor) begin
         case (rq)
            REQ_DIODE: diode_cal_o <= setup_i.value[11:0];
            REQ_CAL: begin
               pole_zero_o <= setup_i.value[7:0];
               temp_cal_o <= setup_i.value[15:8];
            end
            REQ_BOOT: boot_flags_o <= setup_i.value;
            REQ_BIAS: legacy_bias_q <= setup_i.value[11:0];
            REQ_DET_TEMP: legacy_temp_q <= setup_i.value[11:0];
            REQ_IN_OFS: legacy_ofs_q <= setup_i.value[11:0];
            REQ_HK_CAL: begin
               hk_gain_o <= setup_i.value[7:0];
               hk_offset_o <= setup_i.value[15:8];
            end
            REQ_SPEC_OFS: spec_offset_o <= setup_i.value;
            default: ;
         endcase
      end
   end

   // One store strobe covers every setting kept across power loss
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         settings_nv_wr_o <= 1'b0;
         board_eeprom_wr_o <= 1'b0;
      end else if (ce_i) begin
         settings_nv_wr_o <= vendor && (rq >= REQ_DIODE) && (rq <= REQ_SPEC_OFS);
         board_eeprom_wr_o <= vendor && (rq == REQ_DIODE) && board_sync;
      end
   end

   // ************************************************************
   // Boot-time mode, baud rate and setting source
   // ************************************************************
   // Mode, baud and inversion are caught once after reset; later boot flag writes wait for a power cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         boot_done_q <= 1'b0;
         emulation_full_o <= 1'b0;
         baud_fast_o <= 1'b0;
         boot_adc_inv_q <= 1'b0;
      end else if (ce_i && !boot_done_q) begin
         boot_done_q <= 1'b1;
         emulation_full_o <= boot_nv_i[BOOT_MODE_BIT];
         baud_fast_o <= boot_nv_i[BOOT_BAUD_BIT];
         boot_adc_inv_q <= boot_nv_i[BOOT_ADC_INV_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bias_o <= DAC_RESET;
         cooler_o <= DAC_RESET;
         in_offset_o <= DAC_RESET;
         adc_invert_o <= 1'b0;
      end else if (ce_i) begin
         bias_o <= emulation_full_o ? cfg_bias_i : legacy_bias_q;
         cooler_o <= emulation_full_o ? cfg_cooler_i : legacy_temp_q;
         in_offset_o <= emulation_full_o ? cfg_offset_i : legacy_ofs_q;
         adc_invert_o <= emulation_full_o ? cfg_adc_invert_i : boot_adc_inv_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fw_version_o <= 8'h00;
      end else if (ce_i) begin
         fw_version_o <= FW_VERSION;
      end
   end

   // ************************************************************
   // Text block write
   // ************************************************************
   // Each request carries one 32-byte chunk; the index picks the chunk
   assign text_wr = ce_i && text_act_q && data_valid_i && (text_left_q != 16'h0000);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         text_act_q <= 1'b0;
         text_idx_q <= 4'h0;
         text_off_q <= 5'h00;
         text_left_q <= 16'h0000;
      end else if (vendor && (rq == REQ_WRITE_TEXT)) begin
         text_act_q <= (setup_i.index[15:4] == 12'h000);
         text_idx_q <= setup_i.index[3:0];
         text_off_q <= 5'h00;
         text_left_q <= setup_i.length;
      end else if (text_wr) begin
         text_off_q <= text_off_q + 5'h01;
         text_left_q <= text_left_q - 16'h0001;
         if (text_off_q == TEXT_CHUNK_LAST) begin
            text_act_q <= 1'b0;
         end
      end
   end

   // Copy to nonvolatile memory only once the final chunk is complete
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         text_nv_copy_o <= 1'b0;
      end else if (ce_i) begin
         text_nv_copy_o <= text_wr && (text_off_q == TEXT_CHUNK_LAST) && (text_idx_q == TEXT_INDEX_LAST);
      end
   end

   uvcd_text_buf #(
      .WIDTH(8),
      .DEPTH(512),
      .AW(9)
   ) u_text (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .wr_en_i(text_wr),
      .wr_addr_i({text_idx_q, text_off_q}),
      .wr_data_i(data_i),
      .rd_addr_i(text_rd_addr_i),
      .rd_data_o(text_rd_data_o)
   );

   // ************************************************************
   // Shared readback pipe and IN answers
   // ************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shared_q <= SH_CONFIG;
         sel_q <= SRC_CONFIG;
      end else if (ce_i) begin
         if (vendor && (rq == REQ_SELECT) && (setup_i.value == SEL_SCOPE) && scope_ready_i) begin
            shared_q <= SH_ARMED;
            sel_q <= SRC_SCOPE;
         end else if (vendor && (rq == REQ_SELECT) && (setup_i.value == SEL_TEXT)) begin
            shared_q <= SH_ARMED;
            sel_q <= SRC_TEXT;
         end else if (in_req_i && (in_pipe_i == PIPE_SHARED)) begin
            case (shared_q)
               SH_ARMED: shared_q <= SH_PAYLOAD;
               SH_PAYLOAD: begin
                  shared_q <= SH_CONFIG;
                  sel_q <= SRC_CONFIG;
               end
               default: shared_q <= SH_CONFIG;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_ans_valid_o <= 1'b0;
         in_ans_o <= '{zlp: 1'b0, stall: 1'b0, src: SRC_NONE, length: LEN_ZERO};
      end else if (ce_i) begin
         in_ans_valid_o <= in_req_i;
         in_ans_o <= '{zlp: 1'b0, stall: 1'b1, src: SRC_NONE, length: LEN_ZERO};
         if (in_req_i) begin
            case (in_pipe_i)
               PIPE_STATUS: in_ans_o <= '{zlp: !status_ready_i, stall: 1'b0,
                  src: status_ready_i ? SRC_STATUS : SRC_NONE, length: LEN_ZERO};
               PIPE_SPECTRUM: in_ans_o <= '{zlp: !spectrum_ready_i, stall: 1'b0,
                  src: spectrum_ready_i ? SRC_SPECTRUM : SRC_NONE, length: LEN_ZERO};
               PIPE_SHARED: begin
                  case (shared_q)
                     SH_ARMED: in_ans_o <= '{zlp: 1'b1, stall: 1'b0, src: SRC_NONE, length: LEN_ZERO};
                     SH_PAYLOAD: in_ans_o <= '{zlp: 1'b0, stall: 1'b0, src: sel_q, length: LEN_PAYLOAD};
                     default: in_ans_o <= '{zlp: 1'b0, stall: 1'b0, src: SRC_CONFIG, length: LEN_CONFIG};
                  endcase
               end
               // Pipe 0 is OUT only and pipes above 3 do not exist
               default: in_ans_o <= '{zlp: 1'b0, stall: 1'b1, src: SRC_NONE, length: LEN_ZERO};
            endcase
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_zlp_first: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && in_req_i && (in_pipe_i == PIPE_SHARED) && (shared_q == SH_ARMED) && !(vendor && rq == REQ_SELECT)
      |=> in_ans_valid_o && in_ans_o.zlp && (shared_q == SH_PAYLOAD))
      else $error("shared pipe did not answer empty first");

   chk_payload_then_revert: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && in_req_i && (in_pipe_i == PIPE_SHARED) && (shared_q == SH_PAYLOAD) && !vendor
      |=> (in_ans_o.length == LEN_PAYLOAD) && (in_ans_o.src == $past(sel_q)) && (sel_q == SRC_CONFIG))
      else $error("payload read did not return the block and revert");

   chk_scope_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      vendor && (rq == REQ_SELECT) && (setup_i.value == SEL_SCOPE) && !scope_ready_i && (shared_q == SH_CONFIG)
      |=> (shared_q == SH_CONFIG) && (sel_q == SRC_CONFIG))
      else $error("scope select taken while scope unready");

   chk_line_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      vendor && (rq >= REQ_LINE_FIRST) && (rq <= REQ_LINE_LAST)
      |=> general_line_o[$past(rq[2:1])] == $past(rq[0]))
      else $error("general line not driven by request");

   chk_acq_start: assert property (@(posedge clk_i) disable iff (rst_i)
      vendor && (rq == REQ_START) ##1 !(vendor && rq == REQ_STOP) |-> acq_enable_o [*2])
      else $error("acquisition enable not held after start");

   chk_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      vendor && (rq >= REQ_RSV_FIRST) && (rq <= REQ_RSV_LAST)
      |=> setup_ack_o && $stable(general_line_o) && $stable(boot_flags_o) && $stable(acq_enable_o) && !settings_nv_wr_o)
      else $error("reserved request changed state");

   chk_mode_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
      boot_done_q |=> $stable(emulation_full_o) && $stable(baud_fast_o))
      else $error("device mode changed without power cycle");

   chk_full_source: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && emulation_full_o |=> (bias_o == $past(cfg_bias_i)) && (cooler_o == $past(cfg_cooler_i)))
      else $error("full mode did not take configuration settings");

   chk_unready_empty: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && in_req_i && (in_pipe_i == PIPE_STATUS) && !status_ready_i |=> in_ans_o.zlp && !in_ans_o.stall)
      else $error("unready status pipe did not answer empty");

   chk_missing_pipe: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && in_req_i && (in_pipe_i > PIPE_SHARED) |=> in_ans_valid_o && in_ans_o.stall)
      else $error("absent pipe not refused");
endmodule : uvcd_decoder
`default_nettype wire

//--- verilog/uvcd_pkg.sv
// Constants and carrier types for the USB vendor command decoder
`default_nettype none
package uvcd_pkg;
   // ************************************************************
   // Vendor request codes
   // ************************************************************
   localparam logic [7:0] REQ_WRITE_TEXT = 8'h7F;
   localparam logic [7:0] REQ_CLEAR = 8'h80;
   localparam logic [7:0] REQ_START = 8'h82;
   localparam logic [7:0] REQ_STOP = 8'h83;
   localparam logic [7:0] REQ_ARM = 8'h84;
   localparam logic [7:0] REQ_OFS_FINE = 8'h85;
   localparam logic [7:0] REQ_OFS_FULL = 8'h86;
   localparam logic [7:0] REQ_FAST_THR = 8'h87;
   localparam logic [7:0] REQ_LINE_FIRST = 8'h88;
   localparam logic [7:0] REQ_LINE_LAST = 8'h8F;
   localparam logic [7:0] REQ_DIODE = 8'h90;
   localparam logic [7:0] REQ_CAL = 8'h91;
   localparam logic [7:0] REQ_BOOT = 8'h92;
   localparam logic [7:0] REQ_BIAS = 8'h93;
   localparam logic [7:0] REQ_DET_TEMP = 8'h94;
   localparam logic [7:0] REQ_IN_OFS = 8'h95;
   localparam logic [7:0] REQ_HK_CAL = 8'h96;
   localparam logic [7:0] REQ_SPEC_OFS = 8'h97;
   localparam logic [7:0] REQ_SELECT = 8'h98;
   localparam logic [7:0] REQ_RSV_FIRST = 8'h99;
   localparam logic [7:0] REQ_RSV_LAST = 8'h9F;
   localparam logic [1:0] TYPE_VENDOR = 2'h2;
   localparam logic [15:0] SEL_SCOPE = 16'h0000;
   localparam logic [15:0] SEL_TEXT = 16'h0001;
   // ************************************************************
   // Pipes, lengths and boot flag fields
   // ************************************************************
   localparam logic [2:0] PIPE_CFG_OUT = 3'h0;
   localparam logic [2:0] PIPE_STATUS = 3'h1;
   localparam logic [2:0] PIPE_SPECTRUM = 3'h2;
   localparam logic [2:0] PIPE_SHARED = 3'h3;
   localparam logic [9:0] LEN_CONFIG = 10'h040;
   localparam logic [9:0] LEN_PAYLOAD = 10'h200;
   localparam logic [9:0] LEN_ZERO = 10'h000;
   localparam logic [4:0] TEXT_CHUNK_LAST = 5'h1F;
   localparam logic [3:0] TEXT_INDEX_LAST = 4'hF;
   localparam int BOOT_MODE_BIT = 0;
   localparam int BOOT_BAUD_BIT = 1;
   localparam int BOOT_ADC_INV_BIT = 2;
   localparam logic [7:0] FW_VERSION = 8'h50;
   localparam logic [15:0] BOOT_RESET = 16'h0000;
   localparam logic [11:0] DAC_RESET = 12'h000;

   typedef struct packed {
      logic [7:0] req_type;
      logic [7:0] request;
      logic [15:0] value;
      logic [15:0] index;
      logic [15:0] length;
   } uvcd_setup_type;

   typedef enum logic [2:0] {SRC_NONE, SRC_CONFIG, SRC_SCOPE, SRC_TEXT, SRC_STATUS, SRC_SPECTRUM} uvcd_src_type;

   typedef struct packed {
      logic zlp;
      logic stall;
      uvcd_src_type src;
      logic [9:0] length;
   } uvcd_in_ans_type;
endpackage : uvcd_pkg
`default_nettype wire

//--- verilog/uvcd_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`default_nettype none
module uvcd_sync2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : uvcd_sync2
`default_nettype wire

//--- verilog/uvcd_text_buf.sv
// Byte array holding the user text block, one write and one read port
`default_nettype none
module uvcd_text_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   // No reset on the array: contents are reloaded from nonvolatile memory by firmware
   always_ff @(posedge clk_i) begin
      if (ce_i && wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule : uvcd_text_buf
`default_nettype wire

//--- test/uvcd_host.sv
// Host application model: vendor requests and IN pipe reads
`default_nettype none
module uvcd_host
   import uvcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic ans_valid_i,
   input wire uvcd_pkg::uvcd_in_ans_type ans_i,
   output logic setup_valid_o,
   output uvcd_pkg::uvcd_setup_type setup_o,
   output logic in_req_o,
   output logic [2:0] in_pipe_o,
   output logic data_valid_o,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      setup_valid_o = 1'b0;
      setup_o = '0;
      in_req_o = 1'b0;
      in_pipe_o = 3'h0;
      data_valid_o = 1'b0;
      data_o = 8'h00;
   end
   // Vendor type, device recipient, default control pipe
   task automatic req(input logic [7:0] r, input logic [15:0] v);
      @(posedge clk_i);
      setup_valid_o <= 1'b1;
      setup_o <= '{8'h40, r, v, 16'h0000, 16'h0000};
      @(posedge clk_i);
      setup_valid_o <= 1'b0;
   endtask : req
   // One 32-byte text chunk, byte value is seed plus offset
   task automatic wtext(input logic [15:0] idx, input logic [7:0] seed);
      @(posedge clk_i);
      setup_valid_o <= 1'b1;
      setup_o <= '{8'h40, REQ_WRITE_TEXT, 16'h0000, idx, 16'h0020};
      @(posedge clk_i);
      setup_valid_o <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         data_valid_o <= 1'b1;
         data_o <= seed + 8'(i);
         @(posedge clk_i);
      end
      data_valid_o <= 1'b0;
   endtask : wtext
   // A missing answer reads as unknown so that no compare can pass on it
   task automatic rd(input logic [2:0] p, input bit retry, output uvcd_in_ans_type a);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         in_req_o <= 1'b1;
         in_pipe_o <= {1'b0, p[1:0]};
         @(posedge clk_i);
         in_req_o <= 1'b0;
         #1;
         a = (ans_valid_i === 1'b1) ? ans_i : 'x;
         n++;
      end while (retry && a.zlp === 1'b1 && n < 4);
   endtask : rd
endmodule : uvcd_host
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the vendor command decoder
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import uvcd_pkg::*;
   logic clk_i, rst_i, setup_valid_i, setup_ack_o, setup_stall_o, in_req_i, in_ans_valid_o;
   logic status_ready_i, spectrum_ready_i, scope_ready_i, board_present_i, acq_enable_o;
   logic emulation_full_o, baud_fast_o, board_eeprom_wr_o, data_valid_i, text_nv_copy_o, settings_nv_wr_o;
   logic clear_spectrum_o, scope_arm_o, offset_fine_o, offset_full_o, fast_thr_o, adc_invert_o;
   logic [7:0] data_i, text_rd_data_o;
   logic [8:0] text_rd_addr_i;
   logic [11:0] cooler_o, in_offset_o;
   logic [15:0] boot_flags_o;
   logic [2:0] in_pipe_i;
   logic [3:0] general_line_o, exp_line;
   logic [7:0] pole_zero_o, temp_cal_o, hk_gain_o, hk_offset_o, fw_version_o;
   logic [11:0] cfg_bias_i, cfg_cooler_i, cfg_offset_i, diode_cal_o, bias_o;
   logic [15:0] boot_nv_i, spec_offset_o;
   uvcd_setup_type setup_i;
   uvcd_in_ans_type in_ans_o, a;
   int fail_count, checks_done;
   uvcd_decoder u_dut (.clk_i, .rst_i, .ce_i(1'b1), .setup_valid_i, .setup_i, .setup_ack_o, .setup_stall_o,
      .data_valid_i, .data_i, .in_req_i, .in_pipe_i, .in_ans_valid_o, .in_ans_o,
      .status_ready_i, .spectrum_ready_i, .scope_ready_i, .cfg_bias_i, .cfg_cooler_i, .cfg_offset_i,
      .cfg_adc_invert_i(1'b0), .boot_nv_i, .board_present_i, .text_rd_addr_i, .text_rd_data_o,
      .text_nv_copy_o, .clear_spectrum_o, .acq_enable_o, .scope_arm_o, .offset_fine_o,
      .offset_full_o, .fast_thr_o, .general_line_o, .diode_cal_o, .board_eeprom_wr_o,
      .settings_nv_wr_o, .pole_zero_o, .temp_cal_o, .boot_flags_o, .hk_gain_o, .hk_offset_o,
      .spec_offset_o, .bias_o, .cooler_o, .in_offset_o, .adc_invert_o, .emulation_full_o,
      .baud_fast_o, .fw_version_o);
   uvcd_host u_h (.clk_i, .ans_valid_i(in_ans_valid_o), .ans_i(in_ans_o), .setup_valid_o(setup_valid_i),
      .setup_o(setup_i), .in_req_o(in_req_i), .in_pipe_o(in_pipe_i), .data_valid_o(data_valid_i), .data_o(data_i));
   // ******
   // Clock, watchdog, verdict
   // ******
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #40000;
      fail_count++;
      finish_test();
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic vr(input logic [7:0] r, input logic [15:0] v);
      u_h.req(r, v);
      #1;
      `CHK("ack", 1'b1, setup_ack_o)
   endtask : vr
   initial begin
      rst_i = 1'b1;
      status_ready_i = 1'b0;
      spectrum_ready_i = 1'b0;
      scope_ready_i = 1'b0;
      board_present_i = 1'b1;
      cfg_bias_i = 12'h5A5;
      cfg_cooler_i = 12'h3C3;
      cfg_offset_i = 12'h1E1;
      boot_nv_i = 16'h0003;
      exp_line = 4'h0;
      text_rd_addr_i = 9'h000;
      fail_count = 0;
      checks_done = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("fw", FW_VERSION, fw_version_o)
      `CHK("emu", 1'b1, emulation_full_o)
      `CHK("baud", 1'b1, baud_fast_o)
      `CHK("bias", cfg_bias_i, bias_o)
      // Sets lines 0..3 first, then clears them, so every code moves a line
      for (int k = 0; k < 8; k++) begin
         vr(REQ_LINE_FIRST + {4'h0, k[1:0], ~k[2]}, 16'hFFFF);
         exp_line[k[1:0]] = ~k[2];
         `CHK("line", exp_line, general_line_o)
      end
      vr(REQ_DIODE, 16'h0ABC);
      `CHK("diode", 12'hABC, diode_cal_o)
      `CHK("eeprom", 1'b1, board_eeprom_wr_o)
      `CHK("nvwr", 1'b1, settings_nv_wr_o)
      vr(REQ_CAL, 16'h12C4);
      `CHK("calib", 16'h12C4, {temp_cal_o, pole_zero_o})
      vr(REQ_HK_CAL, 16'h3456);
      `CHK("hk", 16'h3456, {hk_offset_o, hk_gain_o})
      vr(REQ_SPEC_OFS, 16'hBEEF);
      `CHK("specofs", 16'hBEEF, spec_offset_o)
      vr(REQ_START, 16'hFFFF);
      `CHK("acq", 1'b1, acq_enable_o)
      vr(REQ_STOP, 16'h0000);
      `CHK("acq", 1'b0, acq_enable_o)
      for (int j = 0; j < 5; j++) begin
         vr(j == 0 ? REQ_CLEAR : REQ_ARM + 8'(j - 1), 16'hFFFF);
         `CHK("pulse", 5'h10 >> j, {clear_spectrum_o, scope_arm_o, offset_fine_o, offset_full_o, fast_thr_o})
      end
      for (int r = 8'h99; r <= 8'h9F; r++) begin
         vr(8'(r), 16'hFFFF);
         `CHK("rsv", {exp_line, 16'hBEEF}, {general_line_o, spec_offset_o})
      end
      u_h.req(8'h81, 16'h0000);
      #1;
      `CHK("stall", 1'b1, setup_stall_o)
      boot_nv_i <= 16'h0000;
      vr(REQ_BOOT, 16'h0006);
      `CHK("boot", 16'h0006, boot_flags_o)
      `CHK("emu", 1'b1, emulation_full_o)
      u_h.rd(PIPE_CFG_OUT, 1'b0, a);
      `CHK("pipe0", 1'b1, a.stall)
      u_h.rd(PIPE_STATUS, 1'b0, a);
      `CHK("stzlp", 1'b1, a.zlp)
      status_ready_i <= 1'b1;
      spectrum_ready_i <= 1'b1;
      u_h.rd(PIPE_STATUS, 1'b0, a);
      `CHK("stat", SRC_STATUS, a.src)
      u_h.rd(PIPE_SPECTRUM, 1'b0, a);
      `CHK("spec", SRC_SPECTRUM, a.src)
      vr(REQ_SELECT, SEL_SCOPE);
      u_h.rd(PIPE_SHARED, 1'b0, a);
      `CHK("cfg", {SRC_CONFIG, LEN_CONFIG}, {a.src, a.length})
      vr(REQ_SELECT, SEL_TEXT);
      u_h.rd(PIPE_SHARED, 1'b0, a);
      `CHK("zlp", 1'b1, a.zlp)
      u_h.rd(PIPE_SHARED, 1'b0, a);
      `CHK("text", {SRC_TEXT, LEN_PAYLOAD}, {a.src, a.length})
      u_h.rd(PIPE_SHARED, 1'b0, a);
      `CHK("cfg", {SRC_CONFIG, LEN_CONFIG}, {a.src, a.length})
      scope_ready_i <= 1'b1;
      vr(REQ_SELECT, SEL_SCOPE);
      u_h.rd(PIPE_SHARED, 1'b1, a);
      `CHK("scope", {SRC_SCOPE, LEN_PAYLOAD}, {a.src, a.length})
      u_h.wtext(16'h000F, 8'h40);
      #1;
      `CHK("nvcopy", 1'b1, text_nv_copy_o)
      text_rd_addr_i <= 9'h1E5;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("textrd", 8'h45, text_rd_data_o)
      // Power cycle with legacy mode stored
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      vr(REQ_BIAS, 16'h0123);
      vr(REQ_DET_TEMP, 16'h0456);
      vr(REQ_IN_OFS, 16'h0789);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("legacy", {1'b0, 36'h123456789, 1'b0}, {emulation_full_o, bias_o, cooler_o, in_offset_o, adc_invert_o})
      finish_test();
   end
endmodule : tb
`default_nettype wire
